// [include/cfp_params.svh]
// Constants of the preprocessed channel setup block
`ifndef CFP_PARAMS_SVH
`define CFP_PARAMS_SVH

// ----------------------------------------------------------------------
// Control memory codes
// ----------------------------------------------------------------------
`define CFP_CODE_UNASSIGNED 4'h0
`define CFP_CODE_SW64 4'h1
`define CFP_CODE_SUB_10 4'h4
`define CFP_CODE_SUB_32 4'h5
`define CFP_CODE_SUB_54 4'h6
`define CFP_CODE_SUB_76 4'h7
`define CFP_CODE_MON_CI 4'h8
`define CFP_CODE_MON_SIG 4'hA
`define CFP_CODE_DN_IDLE 4'hB

// ----------------------------------------------------------------------
// Field layout of the odd slot
// ----------------------------------------------------------------------
`define CFP_D_MSB 7
`define CFP_D_LSB 6
`define CFP_CI_MSB 5
`define CFP_CI_LSB 2
`define CFP_HS_MSB 1
`define CFP_HS_LSB 0
`define CFP_HS_IDLE 2'h3
`define CFP_MON_IDLE 8'hFF
`define CFP_OE_ALL 8'hFF
`define CFP_OE_NONE 8'h00
`define CFP_OE_NO_D 8'h3F
`define CFP_MASK_NO_HS 8'hFC

// ----------------------------------------------------------------------
// Frame timing
// ----------------------------------------------------------------------
`define CFP_NUM_SLOTS 32
`define CFP_FRAME_NS 125000
`define CFP_CLK_NS 40
`define CFP_FRAME_CYCLES (`CFP_FRAME_NS / `CFP_CLK_NS)

`endif

// [include/cfp_pkg.sv]
// Types shared by the preprocessed channel setup block
package cfp_pkg;
  typedef logic [3:0] cfp_code_t;
  typedef logic [7:0] cfp_byte_t;
  typedef logic [4:0] cfp_slot_t;
endpackage : cfp_pkg

// [src/cfp_slot_timer.sv]
// Slot timing divider locked to the frame sync pin
`timescale 1ns/100ps
`include "cfp_params.svh"
module cfp_slot_timer #(
  parameter int NUM_SLOTS = `CFP_NUM_SLOTS,
  parameter int FRAME_CYCLES = `CFP_FRAME_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic frame_sync_pin,
  output cfp_pkg::cfp_slot_t slot_idx,
  output logic slot_en
);
  import cfp_pkg::*;

  localparam int SLOT_CYCLES = FRAME_CYCLES / NUM_SLOTS;

  initial begin
    if (NUM_SLOTS != 32 || SLOT_CYCLES < 2 || SLOT_CYCLES > 4095) begin
      $error("cfp_slot_timer: unsupported frame geometry");
    end
  end

  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic [11:0] div;
  logic frame_edge;

  // ----------------------------------------------------------------------
  // Pin synchroniser and edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= frame_sync_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign frame_edge = sync_b && !sync_c;

  // ----------------------------------------------------------------------
  // Slot divider
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= 12'h000;
      slot_idx <= 5'h00;
      slot_en <= 1'b0;
    end else if (frame_edge) begin
      div <= 12'h000;
      slot_idx <= 5'h00;
      slot_en <= 1'b1;
    end else if (div == 12'(SLOT_CYCLES - 1)) begin
      div <= 12'h000;
      slot_idx <= slot_idx + 5'h01;
      slot_en <= 1'b1;
    end else begin
      div <= div + 12'h001;
      slot_en <= 1'b0;
    end
  end
endmodule : cfp_slot_timer

// [src/cfp_channel_setup.sv]
// Preprocessed channel handling of the configurable slot interface
//
// Contract
// [RULE1] Control memory reset sets every code unassigned
// [RULE2] Standard bus frame holds 32 slots
// [RULE3] Bearer pairs are 0-1, 4-5, 8-9 and onward
// [RULE4] Monitor/D/CI pairs 2-3, 6-7; software sets both
// [RULE5] Each pair and direction configured independently
// [RULE6] Even monitor byte; odd D, CI, handshake
// [RULE7] Handshake mode drives handler handshake bits
// [RULE8] Non-handshake forces both handshake bits high
// [RULE9] Decentral: ignore upstream D, float downstream D
// [RULE10] Upstream CI change raises interrupt, pushes slot
// [RULE11] CI compared against previous frame value
// [RULE12] Decentral codes 1000, 1011, 1000, 0000
// [RULE13] Central: D switched at 16 kbit/s
// [RULE14] Central codes 1010, 1000, odd sub-slot codes
// [RULE15] Software sets sub-slot select to 00
// [RULE16] Sub-slot codes 0111 to 0100; unassigned codes
// [RULE17] Idle D code via six-bit scheme downstream
// [RULE18] Transparent switching uses code 0001
// [RULE19] Transparent: AND PCM low bits with handshake
// [RULE20] Code writes accepted during normal operation
// [RULE21] Monitor even slot, control next odd slot
// [RULE22] Each new CI value reported only once
`timescale 1ns/100ps
`include "cfp_params.svh"
module cfp_channel_setup #(
  parameter int NUM_SLOTS = `CFP_NUM_SLOTS,
  parameter int FRAME_CYCLES = `CFP_FRAME_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic frame_sync_pin,
  input wire logic std_bus_mode,
  input wire logic hs_mode,
  input wire logic cm_reset,
  input wire logic cm_wr_en,
  input wire logic cm_wr_up,
  input cfp_pkg::cfp_slot_t cm_wr_slot,
  input cfp_pkg::cfp_code_t cm_wr_code,
  input cfp_pkg::cfp_byte_t cm_wr_data,
  input wire logic cm_rd_up,
  input cfp_pkg::cfp_slot_t cm_rd_slot,
  output cfp_pkg::cfp_code_t cm_rd_code,
  output cfp_pkg::cfp_byte_t cm_rd_data,
  input cfp_pkg::cfp_byte_t up_byte,
  output cfp_pkg::cfp_byte_t dn_byte,
  output cfp_pkg::cfp_byte_t dn_oe,
  output logic dn_strobe,
  input wire logic [3:0] mon_pair,
  input cfp_pkg::cfp_byte_t mon_tx_byte,
  input wire logic [1:0] mon_tx_hs,
  output cfp_pkg::cfp_byte_t mon_rx_byte,
  output logic mon_rx_valid,
  output logic [1:0] mon_rx_hs,
  output cfp_pkg::cfp_byte_t pcm_dn_ptr,
  input cfp_pkg::cfp_byte_t pcm_dn_byte,
  output cfp_pkg::cfp_byte_t pcm_up_ptr,
  output cfp_pkg::cfp_byte_t pcm_up_byte,
  output cfp_pkg::cfp_byte_t pcm_up_mask,
  output logic pcm_up_we,
  output logic ci_push,
  output cfp_pkg::cfp_slot_t ci_push_slot,
  output logic ci_irq,
  input wire logic ci_irq_clr
);
  import cfp_pkg::*;

  initial begin
    if (NUM_SLOTS != 32) begin
      $error("cfp_channel_setup: frame must hold 32 slots"); // [RULE2]
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Sub-slot code to {valid, pair index}, index 3 means bits 7..6
  function automatic logic [2:0] sub_sel(input cfp_code_t code);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      `CFP_CODE_SUB_76: r = 3'h7;
      `CFP_CODE_SUB_54: r = 3'h6;
      `CFP_CODE_SUB_32: r = 3'h5;
      `CFP_CODE_SUB_10: r = 3'h4;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : sub_sel

  function automatic logic is_mon_code(input cfp_code_t code);
    return (code == `CFP_CODE_MON_CI) || (code == `CFP_CODE_MON_SIG);
  endfunction : is_mon_code

  // ----------------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------------
  cfp_slot_t slot_idx;
  logic slot_en;

  cfp_slot_timer #(
    .NUM_SLOTS(NUM_SLOTS),
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .frame_sync_pin(frame_sync_pin),
    .slot_idx(slot_idx),
    .slot_en(slot_en)
  );

  // ----------------------------------------------------------------------
  // Slot control memory
  // ----------------------------------------------------------------------
  cfp_code_t code_dn [NUM_SLOTS];
  cfp_code_t code_up [NUM_SLOTS];
  cfp_byte_t data_dn [NUM_SLOTS];
  cfp_byte_t data_up [NUM_SLOTS];

  cfp_slot_t ev_slot;
  cfp_slot_t od_slot;
  logic odd_slot;
  logic bearer;
  logic mon_sel;
  cfp_code_t ev_dn_code;
  cfp_code_t od_dn_code;
  cfp_code_t ev_up_code;
  cfp_code_t od_up_code;
  cfp_byte_t ev_dn_data;
  cfp_byte_t ev_up_data;
  logic [3:0] rx_ci;
  logic ci_change;
  logic [1:0] tx_hs;

  assign ev_slot = {slot_idx[4:1], 1'b0}; // [RULE21]
  assign od_slot = {slot_idx[4:1], 1'b1};
  assign odd_slot = slot_idx[0];
  assign bearer = std_bus_mode && !slot_idx[1]; // [RULE3]
  assign mon_sel = (mon_pair == slot_idx[4:1]);
  assign ev_dn_code = code_dn[ev_slot]; // [RULE5]
  assign od_dn_code = code_dn[od_slot];
  assign ev_up_code = code_up[ev_slot];
  assign od_up_code = code_up[od_slot];
  assign ev_dn_data = data_dn[ev_slot];
  assign ev_up_data = data_up[ev_slot];
  assign rx_ci = up_byte[`CFP_CI_MSB:`CFP_CI_LSB];
  assign ci_change = slot_en && odd_slot && !bearer && (ev_up_code == `CFP_CODE_MON_CI) &&
                     (rx_ci != ev_up_data[`CFP_CI_MSB:`CFP_CI_LSB]); // [RULE11]
  assign tx_hs = (hs_mode && mon_sel) ? mon_tx_hs : `CFP_HS_IDLE; // [RULE7] [RULE8]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        code_dn[i] <= `CFP_CODE_UNASSIGNED;
        code_up[i] <= `CFP_CODE_UNASSIGNED;
        data_dn[i] <= 8'h00;
        data_up[i] <= 8'h00;
      end
    end else if (cm_reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        code_dn[i] <= `CFP_CODE_UNASSIGNED; // [RULE1]
        code_up[i] <= `CFP_CODE_UNASSIGNED; // [RULE1]
      end
    end else begin
      if (ci_change) begin
        data_up[ev_slot][`CFP_CI_MSB:`CFP_CI_LSB] <= rx_ci; // [RULE12]
        data_up[ev_slot][`CFP_HS_MSB:`CFP_HS_LSB] <= up_byte[`CFP_HS_MSB:`CFP_HS_LSB];
      end
      if (cm_wr_en && cm_wr_up) begin
        code_up[cm_wr_slot] <= cm_wr_code; // [RULE20]
        data_up[cm_wr_slot] <= cm_wr_data;
      end
      if (cm_wr_en && !cm_wr_up) begin
        code_dn[cm_wr_slot] <= cm_wr_code; // [RULE20]
        data_dn[cm_wr_slot] <= cm_wr_data;
      end
    end
  end

  // Read-back, CI and handshake bits reachable at the even entry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cm_rd_code <= `CFP_CODE_UNASSIGNED;
      cm_rd_data <= 8'h00;
    end else begin
      cm_rd_code <= cm_rd_up ? code_up[cm_rd_slot] : code_dn[cm_rd_slot];
      cm_rd_data <= cm_rd_up ? data_up[cm_rd_slot] : data_dn[cm_rd_slot]; // [RULE8]
    end
  end

  // ----------------------------------------------------------------------
  // Downstream slot assembly
  // ----------------------------------------------------------------------
  cfp_byte_t next_dn_byte;
  cfp_byte_t next_dn_oe;
  logic [2:0] dn_sel;
  logic [1:0] pcm_d;

  assign dn_sel = sub_sel(od_dn_code);

  always_comb begin
    case (dn_sel[1:0])
      2'h3: pcm_d = pcm_dn_byte[7:6];
      2'h2: pcm_d = pcm_dn_byte[5:4];
      2'h1: pcm_d = pcm_dn_byte[3:2];
      default: pcm_d = pcm_dn_byte[1:0];
    endcase
  end

  always_comb begin
    next_dn_byte = 8'h00;
    next_dn_oe = `CFP_OE_NONE;
    if (bearer || !is_mon_code(ev_dn_code)) begin // [RULE4]
      next_dn_byte = 8'h00;
      next_dn_oe = `CFP_OE_NONE;
    end else if (!odd_slot) begin
      next_dn_byte = mon_sel ? mon_tx_byte : `CFP_MON_IDLE; // [RULE6]
      next_dn_oe = `CFP_OE_ALL;
    end else begin
      next_dn_byte = {2'h0, ev_dn_data[`CFP_CI_MSB:`CFP_CI_LSB], tx_hs}; // [RULE6]
      next_dn_oe = `CFP_OE_NO_D;
      if (od_dn_code == `CFP_CODE_SW64) begin
        next_dn_byte = {pcm_dn_byte[7:2], pcm_dn_byte[1:0] & tx_hs}; // [RULE19]
        next_dn_oe = `CFP_OE_ALL;
      end else if (dn_sel[2]) begin
        next_dn_byte[`CFP_D_MSB:`CFP_D_LSB] = pcm_d; // [RULE13] [RULE16]
        next_dn_oe = `CFP_OE_ALL;
      end else if (od_dn_code == `CFP_CODE_DN_IDLE && ev_dn_code == `CFP_CODE_MON_SIG) begin
        next_dn_byte[`CFP_D_MSB:`CFP_D_LSB] = ev_dn_data[`CFP_D_MSB:`CFP_D_LSB];
        next_dn_oe = `CFP_OE_ALL;
      end else begin
        next_dn_oe = `CFP_OE_NO_D; // [RULE9]
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dn_byte <= 8'h00;
      dn_oe <= `CFP_OE_NONE;
      dn_strobe <= 1'b0;
    end else begin
      dn_strobe <= slot_en;
      if (slot_en) begin
        dn_byte <= next_dn_byte;
        dn_oe <= next_dn_oe;
      end
    end
  end

  // Pointer presented one slot ahead of the odd slot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pcm_dn_ptr <= 8'h00;
    end else if (slot_en && !odd_slot) begin
      pcm_dn_ptr <= data_dn[od_slot];
    end
  end

  // ----------------------------------------------------------------------
  // Upstream monitor and D channel
  // ----------------------------------------------------------------------
  logic [2:0] up_sel;

  assign up_sel = sub_sel(od_up_code);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mon_rx_byte <= `CFP_MON_IDLE;
      mon_rx_valid <= 1'b0;
      mon_rx_hs <= `CFP_HS_IDLE;
    end else begin
      mon_rx_valid <= 1'b0;
      if (slot_en && !bearer && mon_sel && is_mon_code(ev_up_code)) begin
        if (!odd_slot) begin
          mon_rx_byte <= up_byte; // [RULE6]
          mon_rx_valid <= 1'b1;
        end else begin
          mon_rx_hs <= up_byte[`CFP_HS_MSB:`CFP_HS_LSB]; // [RULE7]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pcm_up_we <= 1'b0;
      pcm_up_ptr <= 8'h00;
      pcm_up_byte <= 8'h00;
      pcm_up_mask <= 8'h00;
    end else begin
      pcm_up_we <= 1'b0;
      if (slot_en && odd_slot && !bearer && is_mon_code(ev_up_code)) begin
        pcm_up_ptr <= data_up[od_slot];
        if (od_up_code == `CFP_CODE_SW64) begin
          pcm_up_we <= 1'b1;
          pcm_up_byte <= up_byte;
          pcm_up_mask <= `CFP_MASK_NO_HS; // [RULE19]
        end else if (up_sel[2]) begin
          pcm_up_we <= 1'b1; // [RULE13] [RULE14]
          pcm_up_byte <= {4{up_byte[`CFP_D_MSB:`CFP_D_LSB]}};
          pcm_up_mask <= 8'(8'h03 << {up_sel[1:0], 1'b0}); // [RULE16]
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // CI change report
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ci_push <= 1'b0;
      ci_push_slot <= 5'h00;
    end else begin
      ci_push <= ci_change; // [RULE10] [RULE22]
      if (ci_change) begin
        ci_push_slot <= ev_slot;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ci_irq <= 1'b0;
    end else if (ci_change) begin
      ci_irq <= 1'b1; // [RULE10]
    end else if (ci_irq_clr) begin
      ci_irq <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [3:0] last_ci;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_ci <= 4'h0;
    end else if (ci_change) begin
      last_ci <= rx_ci;
    end
  end

  chk_cm_reset_clear: assert property (@(posedge clk) disable iff (!nrst) // [RULE1]
    cm_reset |=> (code_dn[0] == `CFP_CODE_UNASSIGNED && code_up[NUM_SLOTS-1] ==
                  `CFP_CODE_UNASSIGNED))
    else $error("control memory reset left a code assigned");

  chk_bearer_no_report: assert property (@(posedge clk) disable iff (!nrst) // [RULE3]
    (slot_en && bearer) |=> !ci_push)
    else $error("change reported on a bearer pair");

  chk_hs_forced_high: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
    (slot_en && odd_slot && !bearer && !hs_mode && is_mon_code(ev_dn_code) &&
     od_dn_code != `CFP_CODE_SW64) |=> dn_byte[1:0] == `CFP_HS_IDLE)
    else $error("handshake bits not forced high");

  chk_d_float: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
    (slot_en && odd_slot && !bearer && ev_dn_code == `CFP_CODE_MON_CI &&
     od_dn_code == `CFP_CODE_DN_IDLE) |=> dn_oe == `CFP_OE_NO_D)
    else $error("decentral D bits driven");

  chk_ci_report: assert property (@(posedge clk) disable iff (!nrst) // [RULE10]
    ci_change |=> (ci_push && ci_irq && ci_push_slot == $past(ev_slot)))
    else $error("CI change not reported");

  chk_ci_once: assert property (@(posedge clk) disable iff (!nrst) // [RULE22]
    (ci_push && !$past(cm_wr_en, 1)) |-> data_up[ci_push_slot][5:2] == last_ci)
    else $error("stored CI not updated on report");

  chk_sub_slot_mask: assert property (@(posedge clk) disable iff (!nrst) // [RULE16]
    (slot_en && odd_slot && !bearer && is_mon_code(ev_up_code) &&
     od_up_code == `CFP_CODE_SUB_76) |=> (pcm_up_we && pcm_up_mask == 8'hC0))
    else $error("wrong sub-slot for code 0111");

  chk_transp_and: assert property (@(posedge clk) disable iff (!nrst) // [RULE19]
    (slot_en && odd_slot && !bearer && is_mon_code(ev_dn_code) &&
     od_dn_code == `CFP_CODE_SW64) |=> dn_byte[1:0] == ($past(pcm_dn_byte[1:0]) & $past(tx_hs)))
    else $error("transparent handshake bits not ANDed");

  chk_slot_range: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
    slot_en |-> 32'(slot_idx) < NUM_SLOTS)
    else $error("slot index beyond frame");

  cov_ci_push: cover property (@(posedge clk) disable iff (!nrst) ci_push);
  cov_pcm_up: cover property (@(posedge clk) disable iff (!nrst) pcm_up_we);
  cov_mon_rx: cover property (@(posedge clk) disable iff (!nrst) mon_rx_valid);
  cov_cm_reset: cover property (@(posedge clk) disable iff (!nrst) cm_reset ##1 cm_wr_en);
endmodule : cfp_channel_setup

// [tb/cfp_l1_model.sv]
// Layer-1 transceiver model on the subscriber slot interface
`timescale 1ns/100ps
module cfp_l1_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dn_strobe,
  input wire logic [1:0] d_tx,
  input wire logic [3:0] ci_tx,
  output logic [4:0] slot,
  output logic [7:0] up_byte
);
  logic [4:0] nxt;
  assign nxt = slot + 5'h01;
  // Slot count follows the downstream strobes, next byte ready a slot early
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot <= 5'h00;
      up_byte <= 8'h00;
    end else if (dn_strobe) begin
      slot <= nxt;
      if (nxt == 5'h02) begin
        up_byte <= {d_tx, ci_tx, 2'b11};
      end else if (nxt == 5'h01) begin
        up_byte <= 8'h5A;
      end else begin
        up_byte <= ~up_byte;
      end
    end
  end
endmodule : cfp_l1_model

// [tb/test_cfp_channel_setup.sv]
// Self-checking bench of the preprocessed channel setup block
`timescale 1ns/100ps
`include "cfp_params.svh"
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module test_cfp_channel_setup;
  import cfp_pkg::*;
  localparam int FRAME = 320;
  logic clk, nrst, frame_sync_pin, std_bus_mode, hs_mode, cm_reset, cm_wr_en, cm_wr_up;
  logic cm_rd_up, dn_strobe, mon_rx_valid, pcm_up_we, ci_push, ci_irq, ci_irq_clr;
  cfp_slot_t cm_wr_slot, cm_rd_slot, ci_push_slot;
  cfp_code_t cm_wr_code, cm_rd_code;
  cfp_byte_t cm_wr_data, cm_rd_data, up_byte, dn_byte, dn_oe, mon_tx_byte, mon_rx_byte;
  cfp_byte_t pcm_dn_ptr, pcm_dn_byte, pcm_up_ptr, pcm_up_byte, pcm_up_mask;
  logic [3:0] mon_pair, ci_tx;
  logic [1:0] mon_tx_hs, mon_rx_hs, d_tx;
  logic [4:0] l1_slot;
  int fail_count, total_checks;

  cfp_channel_setup #(.FRAME_CYCLES(FRAME)) dut (
    .clk, .nrst, .frame_sync_pin, .std_bus_mode, .hs_mode, .cm_reset, .cm_wr_en, .cm_wr_up,
    .cm_wr_slot, .cm_wr_code, .cm_wr_data, .cm_rd_up, .cm_rd_slot, .cm_rd_code, .cm_rd_data,
    .up_byte, .dn_byte, .dn_oe, .dn_strobe, .mon_pair, .mon_tx_byte, .mon_tx_hs, .mon_rx_byte,
    .mon_rx_valid, .mon_rx_hs, .pcm_dn_ptr, .pcm_dn_byte, .pcm_up_ptr, .pcm_up_byte,
    .pcm_up_mask, .pcm_up_we, .ci_push, .ci_push_slot, .ci_irq, .ci_irq_clr
  );
  cfp_l1_model l1 (.clk, .nrst, .dn_strobe, .d_tx, .ci_tx, .slot(l1_slot), .up_byte);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic cm_wr(input logic up, input cfp_slot_t s, input cfp_code_t c,
                       input cfp_byte_t d);
    @(posedge clk);
    {cm_wr_en, cm_wr_up, cm_wr_slot, cm_wr_code, cm_wr_data} <= {1'b1, up, s, c, d};
    @(posedge clk);
    cm_wr_en <= 1'b0;
  endtask : cm_wr

  task automatic rd(input logic up, input cfp_slot_t s);
    @(posedge clk);
    {cm_rd_up, cm_rd_slot} <= {up, s};
    repeat (2) @(posedge clk);
    #1;
  endtask : rd

  task automatic wait_slot(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(dn_strobe === 1'b1 && l1_slot == 5'(s - 1)) && n < 2000);
    if (n >= 2000) `CHK(n, 0)
  endtask : wait_slot

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    rd(1'b1, 5'h03);
    `CHK(cm_rd_code, `CFP_CODE_UNASSIGNED)
    cm_wr(1'b0, 5'h0E, `CFP_CODE_MON_CI, 8'hC3);
    cm_wr(1'b1, 5'h0E, `CFP_CODE_MON_SIG, 8'hFF);
    rd(1'b0, 5'h0E);
    `CHK({cm_rd_code, cm_rd_data}, 12'h8C3)
    rd(1'b1, 5'h0E);
    `CHK({cm_rd_code, cm_rd_data}, 12'hAFF)
    cm_wr(1'b1, 5'h0E, `CFP_CODE_UNASSIGNED, 8'h00);
    cm_wr(1'b0, 5'h0E, `CFP_CODE_UNASSIGNED, 8'h00);
  endtask : t_regs

  task automatic t_decentral();
    cm_wr(1'b0, 5'h02, `CFP_CODE_MON_CI, 8'hC3);
    cm_wr(1'b0, 5'h03, `CFP_CODE_DN_IDLE, 8'h00);
    cm_wr(1'b1, 5'h02, `CFP_CODE_MON_CI, 8'hFF);
    cm_wr(1'b1, 5'h03, `CFP_CODE_UNASSIGNED, 8'h00);
    wait_slot(3);
    wait_slot(2);
    `CHK(dn_byte, 8'h3C)
    `CHK({mon_rx_valid, mon_rx_byte}, 9'h15A)
    wait_slot(3);
    `CHK(dn_oe, 8'h3F)
    `CHK(dn_byte[5:0], 6'h03)
    `CHK({ci_push, pcm_up_we}, 2'b00)
    @(posedge clk);
    {hs_mode, mon_tx_hs, ci_tx} <= {1'b1, 2'b01, 4'h5};
    wait_slot(3);
    `CHK({ci_push, ci_push_slot, ci_irq}, 7'b1_00010_1)
    `CHK(dn_byte[1:0], 2'b01)
    wait_slot(3);
    `CHK(ci_push, 1'b0)
    rd(1'b1, 5'h02);
    `CHK(cm_rd_data[5:2], 4'h5)
    @(posedge clk);
    ci_irq_clr <= 1'b1;
    @(posedge clk);
    ci_irq_clr <= 1'b0;
    #1;
    `CHK(ci_irq, 1'b0)
  endtask : t_decentral

  task automatic t_central();
    time t0;
    cfp_byte_t m;
    cm_wr(1'b0, 5'h02, `CFP_CODE_MON_SIG, 8'hC3);
    wait_slot(3);
    wait_slot(3);
    `CHK({dn_oe, dn_byte[7:6]}, {8'hFF, 2'b11})
    for (int k = 4; k <= 7; k++) begin
      m = 8'(8'h03 << (2 * (k - 4)));
      cm_wr(1'b0, 5'h03, 4'(k), 8'h11);
      cm_wr(1'b1, 5'h03, 4'(k), 8'h24);
      wait_slot(3);
      t0 = $time;
      wait_slot(3);
      `CHK(int'(($time - t0) / 40), FRAME)
      `CHK({pcm_dn_ptr, pcm_up_ptr, dn_oe}, 24'h1124FF)
      `CHK(dn_byte[7:6], 2'(8'hB4 >> (2 * (k - 4))))
      `CHK({pcm_up_we, pcm_up_mask}, {1'b1, m})
      `CHK(pcm_up_byte & m, 8'hAA & m)
    end
    cm_wr(1'b1, 5'h03, `CFP_CODE_UNASSIGNED, 8'h00);
    wait_slot(3);
    wait_slot(3);
    `CHK(pcm_up_we, 1'b0)
  endtask : t_central

  task automatic t_transparent();
    @(posedge clk);
    pcm_dn_byte <= 8'hB7;
    cm_wr(1'b0, 5'h03, `CFP_CODE_SW64, 8'h11);
    cm_wr(1'b1, 5'h03, `CFP_CODE_SW64, 8'h24);
    wait_slot(3);
    wait_slot(3);
    `CHK(dn_byte, 8'hB5)
    `CHK({pcm_up_we, pcm_up_mask}, 9'h1FC)
    `CHK(pcm_up_byte[7:2], 6'b100101)
  endtask : t_transparent

  task automatic t_bearer_reset();
    cm_wr(1'b0, 5'h00, `CFP_CODE_MON_CI, 8'hC3);
    cm_wr(1'b0, 5'h01, `CFP_CODE_DN_IDLE, 8'h00);
    wait_slot(1);
    wait_slot(1);
    `CHK(dn_oe, 8'h00)
    @(posedge clk);
    {cm_reset, cm_wr_en, cm_wr_up, cm_wr_slot, cm_wr_code} <= {3'b110, 5'h05, 4'h8};
    @(posedge clk);
    {cm_reset, cm_wr_en} <= 2'b00;
    rd(1'b0, 5'h02);
    `CHK({cm_rd_code, cm_rd_data}, 12'h0C3)
    rd(1'b0, 5'h05);
    `CHK(cm_rd_code, `CFP_CODE_UNASSIGNED)
    wait_slot(3);
    wait_slot(3);
    `CHK(dn_oe, 8'h00)
  endtask : t_bearer_reset

  task automatic t_sync();
    wait_slot(3);
    @(posedge clk);
    frame_sync_pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK(dn_strobe, 1'b1)
    @(posedge clk);
    frame_sync_pin <= 1'b0;
  endtask : t_sync

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    {nrst, frame_sync_pin, std_bus_mode, hs_mode, cm_reset, cm_wr_en, cm_wr_up} = 7'b0010000;
    {cm_wr_slot, cm_wr_code, cm_wr_data, cm_rd_up, cm_rd_slot, ci_irq_clr} = '0;
    {mon_pair, mon_tx_byte, mon_tx_hs, pcm_dn_byte} = {4'h1, 8'h3C, 2'b11, 8'hB4};
    {d_tx, ci_tx} = {2'b10, 4'hF};
    fail_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_decentral();
    t_central();
    t_transparent();
    t_bearer_reset();
    t_sync();
    conclude();
  end

  initial begin
    #2000000;
    fail_count++;
    conclude();
  end
endmodule : test_cfp_channel_setup
